// *** acos_scaler.sv ***
// analog current output scaler: per-channel limit check and rescale
// assumes drive quantities come from logic on clk; fitted straps are pins
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module acos_scaler
	import acos_pkg::*;
#(
	parameter logic [7:0] SLOT_LETTER = 8'h48 // ascii slot name
)
(
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     reset,
	// fitted-channel straps from the module options, asynchronous
	input  wire logic [NUM_CH-1:0]        fittedStrap,
	// internal analog quantities, signed per-unit, 0.001 pu per count
	input  wire logic [NUM_SRC*VAL_W-1:0] driveQuant,
	// register port
	input  wire logic [ADDR_W-1:0]        regAddr,
	input  wire logic [31:0]              regWrData,
	input  wire logic                     regWrite,
	input  wire logic                     regRead,
	output logic [31:0]                   regRdData,
	// output stage commands, signed microamps per channel
	output logic [NUM_CH*VAL_W-1:0]       currentCmd,
	output logic [NUM_CH-1:0]             channelInhibit,
	output logic                          initDone
);

	// channel configuration
	logic signed [VAL_W-1:0] lowerLimitPu_q [NUM_CH];
	logic signed [VAL_W-1:0] upperLimitPu_q [NUM_CH];
	acos_range_t             chanRange_q    [NUM_CH];
	logic [SEL_W-1:0]        driveSel_q     [NUM_CH];
	logic [NUM_CH-1:0]       chanEn_q;
	// channel results
	logic signed [VAL_W-1:0] outCmd_q       [NUM_CH];
	logic [NUM_CH-1:0]       inhibit_q;
	// fitted straps and sequencer
	logic [NUM_CH-1:0]       strapMeta_q;
	logic [NUM_CH-1:0]       strapSync_q;
	logic [NUM_CH-1:0]       fitted_q;
	logic [1:0]              initCnt_q;
	acos_state_t             state_q;
	logic [CH_W-1:0]         ch_q;
	logic [31:0]             rdData_q;

	////////////////////////////////////////////////////////////////////////
	// quantity unpacking and per-channel command packing
	logic signed [VAL_W-1:0] quant [NUM_SRC];
	genvar gi;
	for (gi = 0; gi < NUM_SRC; gi++) begin : g_quant
		assign quant[gi] = driveQuant[gi*VAL_W +: VAL_W];
	end
	for (gi = 0; gi < NUM_CH; gi++) begin : g_out
		assign currentCmd[gi*VAL_W +: VAL_W] = outCmd_q[gi];
	end

	////////////////////////////////////////////////////////////////////////
	// operands of the channel under evaluation
	logic signed [VAL_W-1:0] curX;
	logic signed [VAL_W-1:0] curLo;
	logic signed [VAL_W-1:0] curHi;
	logic signed [16:0]      limDiff;
	logic signed [16:0]      xOffset;
	logic                    limInvalid;
	logic                    holdMin;
	logic                    belowLo;
	logic                    aboveHi;
	assign curX    = quant[driveSel_q[ch_q]];
	assign curLo   = lowerLimitPu_q[ch_q];
	assign curHi   = upperLimitPu_q[ch_q];
	assign limDiff = {curHi[VAL_W-1], curHi} - {curLo[VAL_W-1], curLo};
	assign xOffset = {curX[VAL_W-1], curX} - {curLo[VAL_W-1], curLo};
	// the span check is signed so crossed limits count as invalid too
	assign limInvalid = limDiff < MIN_SPAN_PU;
	assign holdMin    = limInvalid || !chanEn_q[ch_q];
	// per-unit against per-unit, no base conversion here
	assign belowLo = curX < curLo;
	assign aboveHi = curX > curHi;

	////////////////////////////////////////////////////////////////////////
	// range decode; the reserved code behaves as 0 to 1 mA
	logic signed [VAL_W-1:0] rngMin;
	logic signed [VAL_W-1:0] rngMax;
	logic [VAL_W-1:0]        rngSpan;
	assign rngMin = (chanRange_q[ch_q] == ACOS_RNG_BIP)  ? BIP_MIN_UA :
	                (chanRange_q[ch_q] == ACOS_RNG_LOOP) ? LOOP_MIN_UA :
	                                                       UNI_MIN_UA;
	assign rngMax = (chanRange_q[ch_q] == ACOS_RNG_BIP)  ? BIP_MAX_UA :
	                (chanRange_q[ch_q] == ACOS_RNG_LOOP) ? LOOP_MAX_UA :
	                                                       UNI_MAX_UA;
	assign rngSpan = rngMax - rngMin;

	////////////////////////////////////////////////////////////////////////
	// gain term: span * (x - lower) / (upper - lower), by long division
	logic [DIV_W-1:0] numer;
	logic             divStart;
	logic             divBusy;
	logic             divDone;
	logic [DIV_W-1:0] divQuot;
	logic             inLinear;
	logic signed [VAL_W-1:0] linearCmd;
	logic signed [VAL_W-1:0] directCmd;
	// in the linear region both factors are non-negative and fit 16 bits
	assign numer = {16'h0000, rngSpan} * {16'h0000, xOffset[15:0]};
	assign inLinear  = !holdMin && !belowLo && !aboveHi;
	assign divStart  = (state_q == ACOS_ST_LOAD) && inLinear;
	assign linearCmd = rngMin + $signed(divQuot[VAL_W-1:0]);
	// clamped or held results need no division
	assign directCmd = holdMin ? rngMin :
	                   belowLo ? rngMin :
	                             rngMax;

	acos_divider u_div (
		.clk      (clk),
		.reset    (reset),
		.start    (divStart),
		.dividend (numer),
		.divisor  (limDiff[15:0]),
		.busy     (divBusy),
		.done     (divDone),
		.quotient (divQuot)
	);

	////////////////////////////////////////////////////////////////////////
	// fitted straps pass two flops before anything reads them
	always_ff @(posedge clk) begin
		if (reset) begin
			strapMeta_q <= 8'h00;
			strapSync_q <= 8'h00;
		end else begin
			strapMeta_q <= fittedStrap;
			strapSync_q <= strapMeta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer: init wait, then round-robin over the channels
	logic initEnd;
	logic storeNow;
	logic signed [VAL_W-1:0] storeVal;
	assign initEnd  = (state_q == ACOS_ST_INIT) && (initCnt_q == INIT_WAIT);
	assign storeNow = ((state_q == ACOS_ST_LOAD) && !inLinear) ||
	                  ((state_q == ACOS_ST_DIV) && divDone);
	assign storeVal = (state_q == ACOS_ST_DIV) ? linearCmd : directCmd;

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q   <= ACOS_ST_INIT;
			initCnt_q <= 2'h0;
			ch_q      <= 3'h0;
		end else begin
			case (state_q)
				ACOS_ST_INIT: begin
					initCnt_q <= initCnt_q + 2'h1;
					if (initEnd) begin
						state_q <= ACOS_ST_LOAD;
					end
				end
				ACOS_ST_LOAD: begin
					if (inLinear) begin
						state_q <= ACOS_ST_DIV;
					end else begin
						ch_q <= ch_q + 3'h1;
					end
				end
				ACOS_ST_DIV: begin
					if (divDone) begin
						state_q <= ACOS_ST_LOAD;
						ch_q    <= ch_q + 3'h1;
					end
				end
				default: begin
					state_q <= ACOS_ST_INIT;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// results: safe minimum from reset until the first evaluation
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < NUM_CH; i++) begin
				outCmd_q[i] <= LOOP_MIN_UA;
			end
			inhibit_q <= 8'h00;
		end else if (storeNow) begin
			outCmd_q[ch_q]  <= storeVal;
			inhibit_q[ch_q] <= limInvalid;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register write decode; writes are ignored until init is over
	logic            wrOk;
	logic            wrInCh;
	logic [CH_W-1:0] wrCh;
	logic [1:0]      wrOfs;
	assign wrOk   = regWrite && (state_q != ACOS_ST_INIT);
	assign wrInCh = !regAddr[5];
	assign wrCh   = regAddr[4:2];
	assign wrOfs  = regAddr[1:0];

	// configuration; defaults stand from reset, enables follow the straps
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < NUM_CH; i++) begin
				lowerLimitPu_q[i] <= RST_LOWER;
				upperLimitPu_q[i] <= RST_UPPER;
				chanRange_q[i]    <= RST_RANGE;
				driveSel_q[i]     <= SEL_W'(i);
			end
			chanEn_q <= 8'h00;
			fitted_q <= 8'h00;
		end else if (initEnd) begin
			fitted_q <= strapSync_q;
			chanEn_q <= strapSync_q;
		end else if (wrOk && wrInCh) begin
			case (wrOfs)
				OFS_LOWER: begin
					lowerLimitPu_q[wrCh] <= regWrData[15:0];
				end
				OFS_UPPER: begin
					upperLimitPu_q[wrCh] <= regWrData[15:0];
				end
				OFS_CTRL: begin
					chanRange_q[wrCh] <= acos_range_t'(
						regWrData[CTRL_RANGE_LSB +: 2]);
					driveSel_q[wrCh]  <= regWrData[CTRL_SEL_LSB +: SEL_W];
					// an absent channel cannot be switched on
					chanEn_q[wrCh] <= regWrData[CTRL_EN_BIT] & fitted_q[wrCh];
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read decode; unmapped addresses read zero
	logic [CH_W-1:0] rdCh;
	logic [3:0]      rdRow;
	logic [31:0]     rdCtrl;
	logic [31:0]     rdStat;
	logic [31:0]     rdMux;
	assign rdCh   = regAddr[4:2];
	assign rdRow  = {1'b0, rdCh} + 4'h1;
	assign rdCtrl = {23'h000000, chanEn_q[rdCh], 1'b0, driveSel_q[rdCh],
	                 2'b00, chanRange_q[rdCh]};
	assign rdStat = {4'h0, rdRow, 6'h00, fitted_q[rdCh], inhibit_q[rdCh],
	                 outCmd_q[rdCh]};
	assign rdMux  = (regAddr == ADDR_FITTED) ?
	                    {23'h000000, (state_q != ACOS_ST_INIT), fitted_q} :
	                (regAddr == ADDR_SLOT) ? {24'h000000, SLOT_LETTER} :
	                regAddr[5] ? 32'h00000000 :
	                (regAddr[1:0] == OFS_LOWER) ?
	                    {{16{lowerLimitPu_q[rdCh][15]}}, lowerLimitPu_q[rdCh]} :
	                (regAddr[1:0] == OFS_UPPER) ?
	                    {{16{upperLimitPu_q[rdCh][15]}}, upperLimitPu_q[rdCh]} :
	                (regAddr[1:0] == OFS_CTRL) ? rdCtrl : rdStat;

	// read data stand for the one cycle after the strobe only
	always_ff @(posedge clk) begin
		if (reset) begin
			rdData_q <= 32'h00000000;
		end else if (regRead) begin
			rdData_q <= rdMux;
		end else begin
			rdData_q <= 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign regRdData      = rdData_q;
	assign channelInhibit = inhibit_q;
	assign initDone       = (state_q != ACOS_ST_INIT);

endmodule

// *** acos_pkg.sv ***
// constants shared by the analog current output scaler and its divider
// assumes one 100 MHz clock and a word-addressed plain register port
package acos_pkg;

	// channel layout: one slot, rows 1 to 8, in sub-modules of two
	localparam int NUM_CH     = 8;
	localparam int CH_W       = 3;
	localparam int NUM_SRC    = 8;
	localparam int SEL_W      = 3;
	localparam int VAL_W      = 16;
	localparam int DIV_W      = 32;

	// per-unit values are signed, one count is 0.001 pu
	localparam logic signed [16:0] MIN_SPAN_PU = 17'sh00064; // 0.1 pu

	// output command in microamps, signed
	localparam logic signed [15:0] BIP_MIN_UA  = 16'shFC18; // -1 mA
	localparam logic signed [15:0] BIP_MAX_UA  = 16'sh03E8; // +1 mA
	localparam logic signed [15:0] LOOP_MIN_UA = 16'sh0FA0; // 4 mA
	localparam logic signed [15:0] LOOP_MAX_UA = 16'sh4E20; // 20 mA
	localparam logic signed [15:0] UNI_MIN_UA  = 16'sh0000; // 0 mA
	localparam logic signed [15:0] UNI_MAX_UA  = 16'sh03E8; // 1 mA

	// output range codes
	typedef enum logic [1:0] {
		ACOS_RNG_BIP  = 2'b00,
		ACOS_RNG_LOOP = 2'b01,
		ACOS_RNG_UNI  = 2'b10,
		ACOS_RNG_RSV  = 2'b11
	} acos_range_t;

	// register map, word addresses
	localparam int         ADDR_W      = 6;
	localparam logic [1:0] OFS_LOWER   = 2'h0;
	localparam logic [1:0] OFS_UPPER   = 2'h1;
	localparam logic [1:0] OFS_CTRL    = 2'h2;
	localparam logic [1:0] OFS_STATUS  = 2'h3;
	localparam logic [5:0] ADDR_FITTED = 6'h20;
	localparam logic [5:0] ADDR_SLOT   = 6'h21;

	// control word fields
	localparam int CTRL_RANGE_LSB = 0;
	localparam int CTRL_SEL_LSB   = 4;
	localparam int CTRL_EN_BIT    = 8;

	// status word fields
	localparam int STAT_INH_BIT   = 16;
	localparam int STAT_FIT_BIT   = 17;
	localparam int STAT_ROW_LSB   = 24;
	localparam int FIT_DONE_BIT   = 8;

	// reset values of a channel entry
	localparam logic signed [15:0] RST_LOWER = 16'sh0000; // 0 pu
	localparam logic signed [15:0] RST_UPPER = 16'sh03E8; // 1 pu
	localparam acos_range_t        RST_RANGE = ACOS_RNG_LOOP;

	// cycles the strap synchroniser needs before it is trusted
	localparam logic [1:0] INIT_WAIT = 2'h3;

	// sequencer states
	typedef enum logic [1:0] {
		ACOS_ST_INIT = 2'b00,
		ACOS_ST_LOAD = 2'b01,
		ACOS_ST_DIV  = 2'b10
	} acos_state_t;

endpackage

// *** acos_divider.sv ***
// unsigned restoring divider, one quotient bit per clock
// assumes start only while idle; divisor must be non-zero
`timescale 1ns/1ps
module acos_divider
	import acos_pkg::*;
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// request
	input  wire logic             start,
	input  wire logic [DIV_W-1:0] dividend,
	input  wire logic [15:0]      divisor,
	// answer
	output logic                  busy,
	output logic                  done,
	output logic [DIV_W-1:0]      quotient
);

	logic [15:0]      rem_q;
	logic [15:0]      div_q;
	logic [DIV_W-1:0] quo_q;
	logic [4:0]       cnt_q;
	logic             busy_q;
	logic             done_q;
	logic [16:0]      remShift;
	logic [16:0]      remSub;
	logic             fits;

	////////////////////////////////////////////////////////////////////////
	// one restoring step: shift in the next dividend bit, try subtract
	assign remShift = {rem_q, quo_q[DIV_W-1]};
	assign remSub   = remShift - {1'b0, div_q};
	assign fits     = remShift >= {1'b0, div_q};

	////////////////////////////////////////////////////////////////////////
	// iteration registers; done is a pulse with the final quotient
	always_ff @(posedge clk) begin
		if (reset) begin
			rem_q  <= 16'h0000;
			div_q  <= 16'h0000;
			quo_q  <= 32'h00000000;
			cnt_q  <= 5'h00;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (start && !busy_q) begin
				rem_q  <= 16'h0000;
				div_q  <= divisor;
				quo_q  <= dividend;
				cnt_q  <= 5'h00;
				busy_q <= 1'b1;
			end else if (busy_q) begin
				rem_q  <= fits ? remSub[15:0] : remShift[15:0];
				quo_q  <= {quo_q[DIV_W-2:0], fits};
				cnt_q  <= cnt_q + 5'h01;
				if (cnt_q == 5'h1F) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end
			end
		end
	end

	assign busy     = busy_q;
	assign done     = done_q;
	assign quotient = quo_q;

endmodule

// *** acos_scaler_chk.sv ***
// port-level assertions for the analog current output scaler
// assumes it is bound into acos_scaler and sees only that module's ports
`timescale 1ns/1ps
module acos_scaler_chk
	import acos_pkg::*;
#(
	parameter logic [7:0] SLOT_LETTER = 8'h48 // arbitrary slot name
)
(
	// clock and reset
	input wire logic                    clk,
	input wire logic                    reset,
	// register port
	input wire logic [ADDR_W-1:0]       regAddr,
	input wire logic                    regRead,
	input wire logic [31:0]             regRdData,
	// output stage
	input wire logic [NUM_CH*VAL_W-1:0] currentCmd,
	input wire logic [NUM_CH-1:0]       channelInhibit,
	input wire logic                    initDone
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	////////////////////////////////////////////////////////////////////////
	// start-up: safe outputs out of reset, then the fitted-channel wait
	chk_rst_safe: assert property (
		$fell(reset) |-> channelInhibit == '0 &&
		currentCmd == {NUM_CH{LOOP_MIN_UA}})
		else $error("outputs not at default after reset");
	chk_init_wait: assert property (
		$fell(reset) |-> !initDone ##[1:5] initDone)
		else $error("init wait not bounded");
	chk_init_hold: assert property (
		initDone |=> initDone)
		else $error("init done dropped");
	chk_cmd_frozen: assert property (
		!initDone |=> $stable(currentCmd))
		else $error("command moved before init done");

	////////////////////////////////////////////////////////////////////////
	// register port: data only in the cycle after a read
	chk_rd_idle: assert property (
		!regRead |=> regRdData == 32'h0)
		else $error("read data without a read");
	chk_rd_unmap: assert property (
		regRead && regAddr > ADDR_SLOT |=> regRdData == 32'h0)
		else $error("unmapped read not zero");
	chk_rd_slot: assert property (
		regRead && regAddr == ADDR_SLOT |=>
		regRdData == {24'h0, SLOT_LETTER})
		else $error("slot letter wrong");

	////////////////////////////////////////////////////////////////////////
	// per channel: inhibited means a range minimum, never outside ranges
	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		logic signed [15:0] cmd;
		assign cmd = currentCmd[i*VAL_W +: VAL_W];
		chk_inh_min: assert property (
			channelInhibit[i] |-> cmd == BIP_MIN_UA ||
			cmd == LOOP_MIN_UA || cmd == UNI_MIN_UA)
			else $error("inhibited channel not at minimum");
		chk_cmd_span: assert property (
			cmd >= BIP_MIN_UA && cmd <= LOOP_MAX_UA)
			else $error("command outside all ranges");
	end
endmodule

bind acos_scaler acos_scaler_chk #(.SLOT_LETTER(SLOT_LETTER)) chk_u (
	.clk(clk), .reset(reset), .regAddr(regAddr), .regRead(regRead),
	.regRdData(regRdData), .currentCmd(currentCmd),
	.channelInhibit(channelInhibit), .initDone(initDone));

// *** acos_loop_load.sv ***
// behavioural current-loop receiver standing on every output channel
// assumes signed microamp commands on the scaler's clock
`timescale 1ns/1ps
module acos_loop_load
	import acos_pkg::*;
(
	// clock
	input wire logic                    clk,
	// commands from the scaler
	input wire logic [NUM_CH*VAL_W-1:0] currentCmd,
	// what the meter reads, one cycle late like a real settling loop
	output logic [NUM_CH*VAL_W-1:0]     loopCurrent_q,
	output logic                        overRange_q
);
	logic overRange_d;

	// a current beyond -1..20 mA would trip the receiving equipment
	always_comb begin
		overRange_d = 1'b0;
		for (int i = 0; i < NUM_CH; i++) begin
			if ($signed(currentCmd[i*VAL_W +: VAL_W]) < BIP_MIN_UA ||
			    $signed(currentCmd[i*VAL_W +: VAL_W]) > LOOP_MAX_UA) begin
				overRange_d = 1'b1;
			end
		end
	end

	// meter sample
	always_ff @(posedge clk) begin
		loopCurrent_q <= currentCmd;
		overRange_q   <= overRange_d;
	end
endmodule

// *** testbench.sv ***
// self-checking bench for the analog current output scaler
// assumes the checker is bound in and rows 1..7 fitted, row 8 empty
`timescale 1ns/1ps
module testbench;
	import acos_pkg::*;
	logic                     clk = 1'b0;
	logic                     reset = 1'b1;
	logic [NUM_CH-1:0]        fittedStrap = 8'h7F;
	logic [NUM_SRC*VAL_W-1:0] driveQuant = '0;
	logic [ADDR_W-1:0]        regAddr = '0;
	logic [31:0]              regWrData = '0;
	logic                     regWrite = 1'b0;
	logic                     regRead = 1'b0;
	logic [31:0]              regRdData;
	logic [NUM_CH*VAL_W-1:0]  currentCmd;
	logic [NUM_CH*VAL_W-1:0]  loopCurrent;
	logic [NUM_CH-1:0]        channelInhibit;
	logic                     initDone;
	logic                     overRange;
	int                       badCount = 0;
	int                       nTests = 0;

	always #5 clk = ~clk;

	acos_scaler dut_u (.clk(clk), .reset(reset), .fittedStrap(fittedStrap),
		.driveQuant(driveQuant), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.currentCmd(currentCmd), .channelInhibit(channelInhibit),
		.initDone(initDone));
	acos_loop_load load_u (.clk(clk), .currentCmd(currentCmd),
		.loopCurrent_q(loopCurrent), .overRange_q(overRange));

	////////////////////////////////////////////////////////////////////////
	// shared bus and compare tasks
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			badCount++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		regWrite  <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge clk);
		regWrite  <= 1'b0;
	endtask
	task automatic reg_rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		#1 d = regRdData; // the only cycle the data stand
	endtask
	task automatic rd_cmp(input logic [5:0] a, input logic [31:0] e);
		logic [31:0] d;
		reg_rd(a, d);
		cmp(d, e);
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// reset values, early write, fitted map, read-only and unmapped places
	task automatic test_start;
		int n;
		cmp(currentCmd, {NUM_CH{LOOP_MIN_UA}});
		cmp({31'h0, initDone}, 32'h0);
		reg_wr(6'h00, 32'h5); // refused, init still pending
		n = 0;
		while (initDone !== 1'b1 && n < 10) begin
			@(posedge clk);
			n++;
		end
		cmp({31'h0, initDone}, 32'h1);
		rd_cmp(6'h00, 32'h0);
		rd_cmp(ADDR_FITTED, 32'h0000017F);
		rd_cmp(ADDR_SLOT, 32'h00000048);
		rd_cmp(6'h0E, 32'h00000131);
		rd_cmp(6'h1E, 32'h00000071);
		rd_cmp(6'h15, 32'h000003E8);
		rd_cmp(6'h17, 32'h06020FA0);
		reg_wr(6'h1F, 32'h0);
		reg_wr(6'h1E, 32'h00000171);
		reg_wr(ADDR_FITTED, 32'h0);
		rd_cmp(6'h1F, 32'h08000FA0);
		rd_cmp(6'h1E, 32'h00000071);
		rd_cmp(ADDR_FITTED, 32'h0000017F);
		rd_cmp(6'h30, 32'h0);
		$display("test_start done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// every range, both clamps, boundaries and invalid spans on channel 2
	function automatic logic [15:0] expect_ua(input int r, lo, hi, x);
		int mn;
		int mx;
		mn = (r == 0) ? BIP_MIN_UA : (r == 1) ? LOOP_MIN_UA : UNI_MIN_UA;
		mx = (r == 0) ? BIP_MAX_UA : (r == 1) ? LOOP_MAX_UA : UNI_MAX_UA;
		if (hi - lo < 100 || x < lo) return 16'(mn);
		if (x > hi) return 16'(mx);
		return 16'(mn + (mx - mn) * (x - lo) / (hi - lo));
	endfunction
	task automatic test_table;
		int rng[10] = '{1, 1, 1, 0, 0, 2, 3, 1, 1, 1};
		int lo[10] = '{0, 0, 0, -1000, -1000, 404, 404, 500, 500, 800};
		int hi[10] = '{1000, 1000, 1000, 1000, 1000, 635, 635, 599, 600, 700};
		int x[10] = '{500, -1, 1001, 1, -1001, 635, 404, 550, 550, 750};
		logic [NUM_SRC*VAL_W-1:0] q;
		logic [15:0] e;
		int src;
		for (int k = 0; k < 10; k++) begin
			src = k % NUM_SRC;
			q = {NUM_SRC{16'h8AD0}}; // decoys on every other source
			q[src*VAL_W +: VAL_W] = 16'(x[k]);
			@(posedge clk);
			driveQuant <= q;
			reg_wr(6'h08, 32'(lo[k]));
			reg_wr(6'h09, 32'(hi[k]));
			reg_wr(6'h0A, 32'(rng[k] + src * 16 + 256));
			repeat (600) @(posedge clk); // two full sweeps
			e = expect_ua(rng[k], lo[k], hi[k], x[k]);
			cmp({16'h0, currentCmd[2*VAL_W +: VAL_W]}, {16'h0, e});
			cmp({31'h0, channelInhibit[2]}, 32'(hi[k] - lo[k] < 100));
			cmp({16'h0, loopCurrent[2*VAL_W +: VAL_W]}, {16'h0, e});
			cmp({31'h0, overRange}, 32'h0);
		end
		// a fitted channel switched off holds its minimum without inhibit
		reg_wr(6'h08, 32'h00000000);
		reg_wr(6'h09, 32'h000003E8);
		reg_wr(6'h0A, 32'h00000011); // 4..20 mA, source 1, off
		rd_cmp(6'h0A, 32'h00000011);
		repeat (600) @(posedge clk);
		cmp({16'h0, currentCmd[2*VAL_W +: VAL_W]}, {16'h0, LOOP_MIN_UA});
		cmp({31'h0, channelInhibit[2]}, 32'h0);
		$display("test_table done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence and watchdog
	initial begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		test_start();
		test_table();
		test_done();
	end
	initial begin
		repeat (20000) @(posedge clk);
		badCount++;
		test_done();
	end
endmodule
